// ==== hdl/hpr_pkg.sv ====
/*
  Shared constants and carrier types for the host read port.
  Assumes a single 25 MHz core clock; host pins are sampled synchronously upstream.
*/
package hpr_pkg;

  // ----------------------------------------
  // Clock and host timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int T_CSH_NS = 13;
  localparam int T_ACYC_NS = 45;
  // Least times round up to whole cycles
  localparam int CSH_CYC = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACYC_CYC = (T_ACYC_NS + CLK_NS - 1) / CLK_NS;
  // Host-side pacing, kept by the far end
  localparam int T_LVL_WAIT_NS = 135;
  localparam int T_DROP_WAIT_NS = 180;
  localparam int LVL_WAIT_READS = 3;
  localparam int DROP_WAIT_READS = 4;

  // ----------------------------------------
  // Read map, byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_RXD_LAST = 8'h1f;
  localparam logic [7:0] OFS_RXS_POP = 8'h40;
  localparam logic [7:0] OFS_TXS_POP = 8'h48;

  // ----------------------------------------
  // Burst limits for register bursts
  // ----------------------------------------
  localparam logic [4:0] BURST_MAX_DW = 5'h08;
  localparam logic [4:0] BURST_MAX_W = 5'h10;
  localparam logic [31:0] DATA_NONE = 32'h0000_0000;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_CSR,
    TGT_RXD,
    TGT_RXS,
    TGT_TXS
  } hpr_tgt_t;

  // One beat of a read cycle
  typedef struct packed {
    hpr_tgt_t tgt;
    logic half;
    logic wide;
    logic [7:0] ofs;
  } hpr_beat_t;

endpackage

// ==== hdl/hpr_read_port.sv ====
/*
  Read side of the asynchronous host port: single and burst reads of CSRs,
  receive data queue and both status queues, plus FIFO-direct reads.
  Assumes host pins arrive already synchronous to core_clk, CSR contents on
  csr_rdata follow csr_addr one cycle later, and each queue head already shows
  its next entry while that queue's pop pulse stands.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Counter values are captured at beat start and held for the whole beat.
// - CSRs and all three queues share one read cycle.
// - Cycle starts when select and strobe both low; ends when either rises.
// - Sixteen-bit reads match 32-bit reads but leave upper half undriven.
// - Register bursts change address under held strobes; at most 8 dword or 16 word.
// - FIFO-direct select forces every read to the receive data queue.
// - FIFO-direct reads still use the low address bits, ignore the upper ones.
// - FIFO-direct bursts have no length limit.
module hpr_read_port
  import hpr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [7:1] host_addr,
  input wire logic fifo_sel,
  input wire logic bus16,
  output logic [31:0] host_data_out,
  output logic host_data_lo_oe_n,
  output logic host_data_hi_oe_n,
  // CSR file
  output logic [7:0] csr_addr,
  input wire logic [31:0] csr_rdata,
  // Queue heads and pops
  input wire logic [31:0] rxd_head,
  input wire logic [31:0] rxs_head,
  input wire logic [31:0] txs_head,
  output logic rxd_pop,
  output logic rxs_pop,
  output logic txs_pop,
  // Status
  output logic burst_overrun
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DRIVE
  } hpr_state_t;

  hpr_state_t state_r;
  hpr_beat_t beat_r;
  hpr_beat_t beat_nxt;
  logic [4:0] beat_cnt_r;
  logic [7:1] addr_r;
  logic [31:0] src_word;
  logic [31:0] data_nxt;
  logic act;
  logic beat_done;
  logic pop_ok;
  logic [4:0] burst_max;

  // ----------------------------------------
  // Cycle detection
  // ----------------------------------------
  assign act = !chip_select_n && !read_strobe_n;
  // A beat completes on release or on a new address under held strobes
  assign beat_done = (state_r == ST_DRIVE) && (!act || host_addr != addr_r);
  // Halfword reads pop only once the upper half has gone out
  assign pop_ok = beat_r.wide || beat_r.half;
  assign burst_max = bus16 ? BURST_MAX_W : BURST_MAX_DW;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb
  begin
    beat_nxt.ofs = {host_addr, 1'b0};
    beat_nxt.half = host_addr[1];
    beat_nxt.wide = !bus16;
    if (fifo_sel)
      beat_nxt.tgt = TGT_RXD;
    else if (beat_cnt_r >= burst_max)
      beat_nxt.tgt = TGT_NONE;
    else if ({host_addr, 1'b0} <= OFS_RXD_LAST)
      beat_nxt.tgt = TGT_RXD;
    // Both halfwords of a status word must reach its queue
    else if ({host_addr[7:2], 2'b00} == OFS_RXS_POP)
      beat_nxt.tgt = TGT_RXS;
    else if ({host_addr[7:2], 2'b00} == OFS_TXS_POP)
      beat_nxt.tgt = TGT_TXS;
    else
      beat_nxt.tgt = TGT_CSR;
  end

  always_comb
  begin
    case (beat_r.tgt)
      TGT_CSR: src_word = csr_rdata;
      TGT_RXD: src_word = rxd_head;
      TGT_RXS: src_word = rxs_head;
      TGT_TXS: src_word = txs_head;
      default: src_word = DATA_NONE;
    endcase
    if (beat_r.wide)
      data_nxt = src_word;
    else
      data_nxt = {16'h0000, beat_r.half ? src_word[31:16] : src_word[15:0]};
  end

  // ----------------------------------------
  // Beat sequencing
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_IDLE: state_r <= act ? ST_FETCH : ST_IDLE;
        ST_FETCH: state_r <= act ? ST_DRIVE : ST_IDLE;
        ST_DRIVE: state_r <= !act ? ST_IDLE : (beat_done ? ST_FETCH : ST_DRIVE);
        default: state_r <= ST_IDLE;
      endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      beat_r <= '0;
      addr_r <= '0;
      csr_addr <= '0;
    end
    else if ((state_r == ST_IDLE && act) || (beat_done && act))
    begin
      beat_r <= beat_nxt;
      addr_r <= host_addr;
      csr_addr <= beat_nxt.ofs;
    end
  end

  // Register bursts are counted; a release restarts the count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      beat_cnt_r <= '0;
    else if (!act)
      beat_cnt_r <= '0;
    else if ((state_r == ST_IDLE || beat_done) && !fifo_sel && beat_cnt_r < BURST_MAX_W)
      beat_cnt_r <= beat_cnt_r + 5'h01;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      burst_overrun <= 1'b0;
    else if (!act)
      burst_overrun <= 1'b0;
    else if (state_r == ST_FETCH && beat_r.tgt == TGT_NONE)
      burst_overrun <= 1'b1;
  end

  // ----------------------------------------
  // Data drive
  // ----------------------------------------
  // Captured once per beat so a counter ticking mid-cycle cannot tear the value
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      host_data_out <= '0;
    else if (state_r == ST_FETCH && act)
      host_data_out <= data_nxt;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_data_lo_oe_n <= 1'b1;
      host_data_hi_oe_n <= 1'b1;
    end
    else if (!act)
    begin
      host_data_lo_oe_n <= 1'b1;
      host_data_hi_oe_n <= 1'b1;
    end
    else if (state_r == ST_FETCH)
    begin
      host_data_lo_oe_n <= 1'b0;
      host_data_hi_oe_n <= !beat_r.wide;
    end
  end

  // ----------------------------------------
  // Queue pops
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_pop <= 1'b0;
      rxs_pop <= 1'b0;
      txs_pop <= 1'b0;
    end
    else
    begin
      rxd_pop <= beat_done && pop_ok && beat_r.tgt == TGT_RXD;
      rxs_pop <= beat_done && pop_ok && beat_r.tgt == TGT_RXS;
      txs_pop <= beat_done && pop_ok && beat_r.tgt == TGT_TXS;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_start_to_drive: assert property ((state_r == ST_IDLE && act) ##1 act |=> !host_data_lo_oe_n)
    else $error("data not driven two edges after cycle start");
  a_release_off: assert property ((state_r == ST_DRIVE && !act) |=> host_data_lo_oe_n && host_data_hi_oe_n)
    else $error("data still driven after strobe release");
  a_data_stable: assert property ((state_r == ST_DRIVE) ##1 (state_r == ST_DRIVE) |-> $stable(host_data_out))
    else $error("read data changed within a beat");
  a_upper_undriven: assert property (!host_data_hi_oe_n |-> beat_r.wide)
    else $error("upper half driven on a halfword read");
  a_direct_target: assert property ((state_r == ST_IDLE && act && fifo_sel) |=> beat_r.tgt == TGT_RXD)
    else $error("direct read not routed to receive data queue");
  a_direct_half: assert property ((state_r == ST_IDLE && act && fifo_sel) |=> beat_r.half == $past(host_addr[1]))
    else $error("direct read lost low address bit");
  a_burst_refuse: assert property ((state_r == ST_FETCH && act && beat_r.tgt == TGT_NONE) |=> host_data_out == DATA_NONE)
    else $error("beat past burst limit returned data");
  a_abort_no_pop: assert property ((state_r == ST_FETCH && !act) |=> !rxd_pop && !rxs_pop && !txs_pop)
    else $error("aborted overlap popped a queue");
  a_pop_after_beat: assert property (rxd_pop |-> $past(state_r) == ST_DRIVE && $past(pop_ok))
    else $error("pop without a completed beat");
  a_single_pop: assert property ((rxd_pop || rxs_pop || txs_pop) |=> !(rxd_pop || rxs_pop || txs_pop))
    else $error("two pops for one beat");

  c_single_read: cover property ((state_r == ST_IDLE && act) ##1 act ##1 act ##1 !act);
  c_burst_regs: cover property (beat_done && act && !fifo_sel ##[1:20] burst_overrun);
  c_direct_burst: cover property (rxd_pop && fifo_sel ##[1:10] rxd_pop);
  c_halfword: cover property (!host_data_lo_oe_n && host_data_hi_oe_n);

endmodule

`default_nettype wire

// ==== tb/hpr_host_model.sv ====
/*
  Host model for the read port: select, strobe, address and direct select.
  Assumes the bench calls its tasks from one process, in step with core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hpr_host_model
(
  // Clock
  input wire logic core_clk,
  // Host pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic [7:1] host_addr,
  output logic fifo_sel,
  output logic bus16
);
  initial
  begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    host_addr = 7'h00;
    fifo_sel = 1'b0;
    bus16 = 1'b0;
  end

  // One beat; strobes go low in either order
  task automatic beat(input logic [7:0] o, input logic s, input logic w, input logic rd_first);
    @(posedge core_clk);
    host_addr <= o[7:1];
    fifo_sel <= s;
    bus16 <= w;
    if (rd_first)
    begin
      read_strobe_n <= 1'b0;
    end
    else
    begin
      chip_select_n <= 1'b0;
    end
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Address is scrambled once released, so stale decode shows up
  task automatic let_go(input logic rd_only);
    @(posedge core_clk);
    read_strobe_n <= 1'b1;
    if (!rd_only)
    begin
      chip_select_n <= 1'b1;
    end
    host_addr <= ~host_addr;
    repeat (2) @(posedge core_clk);
  endtask

  // Overlap dropped before data capture
  task automatic abort_rd(input logic [7:0] o);
    @(posedge core_clk);
    host_addr <= o[7:1];
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    @(posedge core_clk);
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_host_pio_read_port.sv ====
/*
  Bench for the host read port: host model, queue and CSR stand-ins, checks.
  Assumes registered one-cycle pops and CSR data valid a cycle after csr_addr.
  A queue stand-in shows its next entry while its pop pulse stands.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_host_pio_read_port
  import hpr_pkg::*;
;
  localparam logic [7:0] PROBE_OFS = 8'h64;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, rd_n, sel, b16, lo_n, hi_n, ov;
  logic [7:1] addr;
  logic [31:0] dout, csr_rdata, r;
  logic [7:0] csr_addr, o;
  logic [7:0] tick = 8'h00;
  logic [2:0] pop;
  logic [31:0] mem [3][64];
  int cnt [3];
  int exp_n [3];
  int nb = 0;
  int cyc = 0;
  int miscompares = 0;
  int checks_done = 0;
  integer seed = 32'h9ad67543;

  // Counter byte moves every cycle, so a late capture is visible
  assign csr_rdata = {csr_addr, ~csr_addr, 8'h3c, tick};
  always #20 core_clk = ~core_clk;

  hpr_host_model host (.core_clk(core_clk), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .host_addr(addr), .fifo_sel(sel), .bus16(b16));
  hpr_read_port uut (.core_clk(core_clk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .host_addr(addr), .fifo_sel(sel), .bus16(b16), .host_data_out(dout), .host_data_lo_oe_n(lo_n),
    .host_data_hi_oe_n(hi_n), .csr_addr(csr_addr), .csr_rdata(csr_rdata),
    .rxd_head(mem[0][cnt[0] + int'(pop[0])]), .rxs_head(mem[1][cnt[1] + int'(pop[1])]),
    .txs_head(mem[2][cnt[2] + int'(pop[2])]), .rxd_pop(pop[0]), .rxs_pop(pop[1]),
    .txs_pop(pop[2]), .burst_overrun(ov));

  always @(posedge core_clk)
  begin
    tick <= tick + 8'h01;
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++)
    begin
      if (pop[i] === 1'b1)
      begin
        cnt[i] <= cnt[i] + 1;
      end
    end
    if (cyc == 4000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Reference model of one beat
  // ----------------------------------------
  task automatic rd(input logic [7:0] a, input logic s, input logic w, input logic f);
    int q;
    logic [31:0] e;
    logic [31:0] m;
    logic [31:0] d;
    logic ovr;
    q = s ? 0 : (a < 8'h20) ? 0 : ((a & 8'hfc) == 8'h40) ? 1 : ((a & 8'hfc) == 8'h48) ? 2 : 3;
    if (!s)
    begin
      nb++;
    end
    ovr = !s && (nb > (w ? 16 : 8));
    host.beat(a, s, w, f);
    #1;
    e = (q == 3) ? {a & 8'hfe, ~(a & 8'hfe), 8'h3c, 8'h00} : mem[q][exp_n[q]];
    m = (q == 3) ? 32'hffff_ff00 : 32'hffff_ffff;
    if (w)
    begin
      e = {16'h0000, a[1] ? e[31:16] : e[15:0]};
      m = {16'hffff, a[1] ? m[31:16] : m[15:0]};
    end
    if (ovr)
    begin
      e = 32'h0000_0000;
      m = 32'hffff_ffff;
    end
    else if (q < 3 && (a[1] || !w))
    begin
      exp_n[q]++;
    end
    chk("data", dout & m, e);
    chk("overrun", ov, ovr);
    if (!ovr)
    begin
      chk("oe", {lo_n, hi_n}, {1'b0, w});
    end
    d = dout;
    @(posedge core_clk);
    #1;
    chk("hold", dout, d);
  endtask

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 192; i++)
    begin
      mem[i / 64][i % 64] = $random(seed);
    end
    repeat (20) @(posedge core_clk);
    #1;
    chk("reset oe", {lo_n, hi_n, pop}, 5'h1f - 5'h07);
    @(posedge core_clk);
    rst <= 1'b0;
    // Singles on every target, both widths; both strobe orders on status queues, CSRs strobe first, receive data select first
    for (int k = 0; k < 8; k++)
    begin
      r = $random(seed);
      o = (k % 4 == 0) ? {3'h0, r[4:2], 2'h0} : (k % 4 == 1) ? 8'h40 : (k % 4 == 2) ? 8'h48 : {1'b1, r[6:2], 2'h0};
      rd(o, 1'b0, k[2], k[0]);
      host.let_go(k[1]);
      nb = 0;
      if (k[2])
      begin
        rd(o | 8'h02, 1'b0, 1'b1, k[1]);
        host.let_go(k[0]);
        nb = 0;
      end
    end
    // Probe reads pace the level read after a status pop
    rd(8'h40, 1'b0, 1'b0, 1'b0);
    host.let_go(1'b0);
    for (int k = 0; k < 5; k++)
    begin
      nb = 0;
      rd(k < 4 ? PROBE_OFS : 8'h6c, 1'b0, 1'b0, 1'b1);
      host.let_go(1'b0);
    end
    // Register bursts past their limits, then direct bursts
    for (int w = 0; w < 2; w++)
    begin
      nb = 0;
      for (int k = 0; k < (w ? 17 : 10); k++)
      begin
        rd(8'h80 + 8'(k * (w ? 2 : 4)), 1'b0, w[0], 1'b0);
      end
      host.let_go(1'b0);
      chk("overrun clear", ov, 1'b0);
      for (int k = 0; k < (w ? 6 : 20); k++)
      begin
        r = $random(seed);
        rd({r[7:3], k[1:0] & {~w[0], 1'b1}, 1'b0}, 1'b1, w[0], 1'b1);
      end
      host.let_go(1'b1);
    end
    host.abort_rd(8'h48);
    chk("abort oe", {lo_n, hi_n}, 2'b11);
    for (int q = 0; q < 3; q++)
    begin
      chk("pops", cnt[q], exp_n[q]);
    end
    test_done();
  end
endmodule
`default_nettype wire
